/* File: bench/ocb_chk.sv */
// Checker of the bus wires between the host end and the card end
`timescale 1ns/10ps
`default_nettype none
module ocb_chk (
  input wire logic                      clk,
  input wire logic                      reset,
  input wire logic                      bus_clk,
  input wire logic                      bus_reset_output,
  input wire logic                      ale,
  input wire logic                      dma_address_enable,
  input wire logic [ocb_pkg::CMD_W-1:0] cmd_n,
  input wire logic                      dma_terminal_count_pulse,
  input wire logic                      host_data_oe_n,
  input wire logic                      card_data_oe_n,
  input wire logic                      bus_wait_line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Address phase, then one command
  sequence s_ale_hold;
    ale [*2];
  endsequence
  sequence s_cmd_start;
    !ale && cmd_n != ocb_pkg::CMD_IDLE;
  endsequence
  a_ale_then_cmd: assert property ($rose(ale) |-> s_ale_hold ##[1:3] s_cmd_start)
    else $error("strobe not followed by a command");
  a_no_ale_dma: assert property (ale |-> !dma_address_enable)
    else $error("strobe while DMA owns the bus");
  a_owner_idle: assert property ($changed(dma_address_enable) |-> cmd_n == ocb_pkg::CMD_IDLE)
    else $error("bus owner changed mid command");
  a_cmd_single: assert property (cmd_n != ocb_pkg::CMD_IDLE |-> $onehot(~cmd_n))
    else $error("two commands at once");
  a_write_drives: assert property (!cmd_n[ocb_pkg::CMD_IOW] || !cmd_n[ocb_pkg::CMD_MEMW] |-> !host_data_oe_n)
    else $error("write without host data");
  a_read_release: assert property (!cmd_n[ocb_pkg::CMD_IOR] || !cmd_n[ocb_pkg::CMD_MEMR] |-> host_data_oe_n)
    else $error("host drives data on read");
  a_one_driver: assert property (!(!host_data_oe_n && !card_data_oe_n))
    else $error("data bus contention");
  a_wait_stretch: assert property (cmd_n != ocb_pkg::CMD_IDLE && !bus_wait_line |=> cmd_n != ocb_pkg::CMD_IDLE)
    else $error("cycle ended while wait low");
  a_tc_pulse: assert property (dma_terminal_count_pulse |=> !dma_terminal_count_pulse)
    else $error("terminal count longer than a clock");
  a_bus_reset_output_fall: assert property ($fell(bus_reset_output) |-> !bus_clk)
    else $error("bus reset off the falling edge");
  a_bus_reset_output_start: assert property ($fell(reset) |-> bus_reset_output)
    else $error("bus reset low after power-up");
  // Bus clock rises counted while the wait line is held low
  logic       bclk_prev_ff;
  logic [3:0] wait_rises_ff;
  always_ff @(posedge clk) begin
    bclk_prev_ff <= bus_clk;
    if (reset || bus_wait_line) begin
      wait_rises_ff <= 4'h0;
    end else if (bus_clk && !bclk_prev_ff && wait_rises_ff != 4'hF) begin
      wait_rises_ff <= wait_rises_ff + 4'h1;
    end
  end
  // Wait released during a command, then the command ends
  sequence s_wait_freed;
    $rose(bus_wait_line) && cmd_n != ocb_pkg::CMD_IDLE;
  endsequence
  sequence s_cycle_over;
    cmd_n == ocb_pkg::CMD_IDLE;
  endsequence
  a_wait_limit: assert property (wait_rises_ff <= 4'(ocb_pkg::MAX_WAIT_CLKS))
    else $error("wait line held too long");
  a_wait_release: assert property (s_wait_freed |-> ##[1:4] s_cycle_over)
    else $error("cycle not ended after wait release");
endmodule : ocb_chk
`default_nettype wire

/* File: bench/option_card_bus_signalling_test.sv */
// Testbench joining host and card ends across the bus
`timescale 1ns/10ps
`default_nettype none
module option_card_bus_signalling_test;
  logic        clk = 0, reset = 1, fast = 0, lv = 0, dg = 0, rv = 0, rw = 0, rio = 0, tce = 0, ack = 0, upe = 0;
  logic [19:0] ra = 0, la;
  logic [7:0]  wd = 0, rd, wdat, lw;
  logic [4:0]  us = 0, uc = 0, pend;
  logic [2:0]  ai = 0, idx;
  logic [3:0]  wi, lwi;
  logic        rr, rsv, act, pe, wv, tcs;
  int          err_total = 0, comparisons = 0, lat, tcn = 0;
  ocb_if ifc ();
  ocb_host i_ocb_host (.clk, .reset, .bus(ifc.host_mp), .fast_mode(fast), .low_voltage(lv), .dma_grant(dg),
    .req_valid(rv), .req_ready(rr), .req_write(rw), .req_io(rio), .req_addr(ra), .req_wdata(wd),
    .rsp_valid(rsv), .rsp_rdata(rd), .latched_addr(la), .dma_count_done(tce), .irq_pending(pend),
    .irq_active(act), .irq_index(idx), .irq_ack(ack), .irq_ack_index(ai), .parity_error(pe));
  ocb_card i_ocb_card (.clk, .reset, .bus(ifc.card_mp), .user_irq_set(us), .user_irq_clear(uc),
    .user_parity_error(upe), .wr_valid(wv), .wr_index(wi), .wr_data(wdat), .count_done_seen(tcs));
  ocb_chk i_ocb_chk (.clk, .reset, .bus_clk(ifc.bus_clk), .bus_reset_output(ifc.bus_reset_output),
    .ale(ifc.ale), .dma_address_enable(ifc.dma_address_enable), .cmd_n(ifc.cmd_n),
    .dma_terminal_count_pulse(ifc.dma_terminal_count_pulse), .host_data_oe_n(ifc.host_data_oe_n),
    .card_data_oe_n(ifc.card_data_oe_n), .bus_wait_line(ifc.bus_wait_line));
  // Clock and capture of card writes and count pulses
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (wv === 1'b1) begin
      lwi <= wi;
      lw <= wdat;
    end
    if (tcs === 1'b1) tcn <= tcn + 1;
  end
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic endt(input string s);
    $display("%s finished, %0d mismatches so far", s, err_total);
  endtask : endt
  // One bus cycle: hold request until taken, then time the response
  task automatic op(input logic w, input logic io, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rw <= w;
    rio <= io;
    ra <= a;
    wd <= d;
    rv <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (rr !== 1'b1 && n < 200);
    rv <= 0;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (rsv !== 1'b1 && lat < 200);
    if (n >= 200 || lat >= 200) begin
      err_total++;
      $display("unexpected at %0t: bus cycle timeout", $time);
      tally_and_finish();
    end
  endtask : op
  // Main sequence
  initial begin
    cyc(6);
    reset <= 0;
    cyc(20);
    op(0, 1, 20'h00400, 8'h00);
    chk(rd, 8'hFF);
    chk(20'(lat), 20'(3 * ocb_pkg::DIV_SLOW + 1));
    chk(la, 20'h00400);
    chk(ifc.addr, 20'h00400);
    endt("miss read");
    op(1, 1, 20'h00305, 8'hA5);
    chk(20'(lat > 3 * ocb_pkg::DIV_SLOW + 1), 1);
    chk(20'(lat % ocb_pkg::DIV_SLOW), 1);
    cyc(3);
    chk({lwi, lw}, 20'h005A5);
    chk(20'(lwi), 20'h5);
    op(0, 1, 20'h00305, 8'h00);
    chk(rd, 8'hA5);
    op(1, 0, 20'hD0003, 8'h5A);
    op(0, 0, 20'hD0003, 8'h00);
    chk(rd, 8'h5A);
    endt("card access");
    dg <= 1;
    cyc(8);
    op(1, 0, 20'hD000C, 8'h3C);
    chk(la, 20'hD0003);
    dg <= 0;
    cyc(8);
    op(0, 0, 20'hD000C, 8'h00);
    chk(rd, 8'h3C);
    fast <= 1;
    cyc(8);
    op(0, 1, 20'h00400, 8'h00);
    chk(20'(lat), 20'(3 * ocb_pkg::DIV_FAST + 1));
    fast <= 0;
    endt("dma and fast");
    us <= 5'h1F;
    cyc(1);
    us <= 0;
    cyc(8);
    chk(pend, 5'h1F);
    for (int i = 0; i < 5; i++) begin
      chk(idx, 20'(i));
      ack <= 1;
      ai <= 3'(i);
      cyc(1);
      ack <= 0;
      cyc(3);
    end
    chk({act, pend}, 20'h0);
    uc <= 5'h1F;
    cyc(1);
    uc <= 0;
    endt("interrupts");
    upe <= 1;
    cyc(8);
    chk(pe, 1);
    upe <= 0;
    cyc(8);
    chk(pe, 0);
    tce <= 1;
    cyc(1);
    tce <= 0;
    cyc(4);
    chk(20'(tcn), 1);
    endt("parity and count");
    lv <= 1;
    cyc(12);
    chk(ifc.bus_reset_output, 1);
    lv <= 0;
    cyc(12);
    chk(ifc.bus_reset_output, 0);
    endt("low voltage");
    tally_and_finish();
  end
endmodule : option_card_bus_signalling_test
`default_nettype wire

/* File: rtl/ocb_card.sv */
// Option card end: decode, wait stretch, small register window, interrupts
`timescale 1ns/10ps
`default_nettype none
module ocb_card #(
  parameter logic [15:0] IO_BASE   = 16'h0030,
  parameter logic [15:0] MEM_BASE  = 16'hD000,
  parameter int          WAIT_CLKS = 2
) (
  input  wire logic                             clk,
  input  wire logic                             reset,
  ocb_if.card_mp                                bus,
  input  wire logic [ocb_pkg::IRQ_N-1:0]        user_irq_set,
  input  wire logic [ocb_pkg::IRQ_N-1:0]        user_irq_clear,
  input  wire logic                             user_parity_error,
  output logic                                  wr_valid,
  output logic [ocb_pkg::CARD_IDX_W-1:0]        wr_index,
  output logic [ocb_pkg::DATA_W-1:0]            wr_data,
  output logic                                  count_done_seen
);
  localparam int WAIT_LIM = (WAIT_CLKS > ocb_pkg::MAX_WAIT_CLKS) ? ocb_pkg::MAX_WAIT_CLKS : WAIT_CLKS;

  ocb_pkg::ocb_card_st_e                st_ff, nxt_st;
  logic [ocb_pkg::WAIT_CNT_W-1:0]       wcnt_ff, nxt_wcnt;
  logic [ocb_pkg::ADDR_W-1:0]           cap_ff, nxt_cap;
  logic                                 ale_prev_ff, bclk_prev_ff;
  logic [ocb_pkg::CMD_W-1:0]            cmd_prev_ff;
  logic [ocb_pkg::DATA_W-1:0]           mem_ff [ocb_pkg::CARD_WORDS];
  logic [ocb_pkg::DATA_W-1:0]           dout_ff, nxt_dout;
  logic                                 doe_n_ff, nxt_doe_n;
  logic                                 wr_ff, nxt_wr;
  logic [ocb_pkg::CARD_IDX_W-1:0]       widx_ff, nxt_widx;
  logic [ocb_pkg::DATA_W-1:0]           wdat_ff, nxt_wdat;
  logic [ocb_pkg::IRQ_N-1:0]            irq_ff, nxt_irq;
  logic                                 nmi_oe_n_ff, eoc_ff;
  logic                                 rst_all;
  logic [ocb_pkg::ADDR_W-1:0]           sel_addr;
  logic                                 io_cmd, mem_cmd, hit, rd_hit, cmd_start, bclk_rise;
  logic [ocb_pkg::CMD_W-1:0]            cmd_end;

  // Decode and wait stretch
  always_comb begin
    rst_all   = reset | bus.bus_reset_output;
    nxt_cap   = cap_ff;
    if (ale_prev_ff && !bus.ale && !bus.dma_address_enable) begin
      nxt_cap = bus.addr;
    end
    // Strobe fall and command start share one edge, so decode the fresh capture
    sel_addr  = bus.dma_address_enable ? bus.addr : nxt_cap;
    io_cmd    = !bus.cmd_n[ocb_pkg::CMD_IOR] || !bus.cmd_n[ocb_pkg::CMD_IOW];
    mem_cmd   = !bus.cmd_n[ocb_pkg::CMD_MEMR] || !bus.cmd_n[ocb_pkg::CMD_MEMW];
    hit       = (io_cmd && sel_addr[19:4] == IO_BASE) || (mem_cmd && sel_addr[19:4] == MEM_BASE);
    rd_hit    = hit && (!bus.cmd_n[ocb_pkg::CMD_IOR] || !bus.cmd_n[ocb_pkg::CMD_MEMR]);
    cmd_start = (cmd_prev_ff == ocb_pkg::CMD_IDLE) && (bus.cmd_n != ocb_pkg::CMD_IDLE);
    cmd_end   = ~cmd_prev_ff & bus.cmd_n;
    bclk_rise = bus.bus_clk && !bclk_prev_ff;
    nxt_st    = st_ff;
    nxt_wcnt  = wcnt_ff;
    case (st_ff)
      ocb_pkg::CS_IDLE: begin
        if (cmd_start && hit && WAIT_LIM > 0) begin
          nxt_st   = ocb_pkg::CS_HOLD;
          nxt_wcnt = ocb_pkg::WAIT_CNT_W'(WAIT_LIM);
        end
      end
      ocb_pkg::CS_HOLD: begin
        if (bclk_rise) begin
          nxt_wcnt = wcnt_ff - 4'h1;
          if (wcnt_ff == 4'h1) begin
            nxt_st = ocb_pkg::CS_DONE;
          end
        end
      end
      ocb_pkg::CS_DONE: begin
        if (bus.cmd_n == ocb_pkg::CMD_IDLE) begin
          nxt_st = ocb_pkg::CS_IDLE;
        end
      end
      default: nxt_st = ocb_pkg::CS_IDLE;
    endcase
  end

  // Read drive and write capture
  always_comb begin
    nxt_dout  = mem_ff[sel_addr[3:0]];
    nxt_doe_n = !rd_hit;
    nxt_wr    = 1'b0;
    nxt_widx  = widx_ff;
    nxt_wdat  = wdat_ff;
    if (hit || (cmd_end[ocb_pkg::CMD_IOW] || cmd_end[ocb_pkg::CMD_MEMW])) begin
      nxt_widx = sel_addr[3:0];
    end
    // Sample data while the write command stands; the host lets go with it
    if (hit && !(bus.cmd_n[ocb_pkg::CMD_IOW] && bus.cmd_n[ocb_pkg::CMD_MEMW])) begin
      nxt_wdat = bus.data;
    end
    if ((cmd_end[ocb_pkg::CMD_IOW] || cmd_end[ocb_pkg::CMD_MEMW]) && sel_addr[19:4] ==
        (cmd_end[ocb_pkg::CMD_IOW] ? IO_BASE : MEM_BASE)) begin
      nxt_wr   = 1'b1;
    end
    // Requests stay high until cleared; a new set beats a clear
    nxt_irq = (irq_ff & ~user_irq_clear) | user_irq_set;
  end

  // Card registers
  always_ff @(posedge clk) begin
    if (rst_all) begin
      st_ff        <= ocb_pkg::CS_IDLE;
      wcnt_ff      <= '0;
      cap_ff       <= '0;
      ale_prev_ff  <= 1'b0;
      bclk_prev_ff <= 1'b0;
      cmd_prev_ff  <= ocb_pkg::CMD_IDLE;
      dout_ff      <= '0;
      doe_n_ff     <= 1'b1;
      wr_ff        <= 1'b0;
      widx_ff      <= '0;
      wdat_ff      <= '0;
      irq_ff       <= '0;
      nmi_oe_n_ff  <= 1'b1;
      eoc_ff       <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      wcnt_ff      <= nxt_wcnt;
      cap_ff       <= nxt_cap;
      ale_prev_ff  <= bus.ale;
      bclk_prev_ff <= bus.bus_clk;
      cmd_prev_ff  <= bus.cmd_n;
      dout_ff      <= nxt_dout;
      doe_n_ff     <= nxt_doe_n;
      wr_ff        <= nxt_wr;
      widx_ff      <= nxt_widx;
      wdat_ff      <= nxt_wdat;
      irq_ff       <= nxt_irq;
      nmi_oe_n_ff  <= !user_parity_error;
      eoc_ff       <= bus.dma_terminal_count_pulse;
    end
  end

  // Register window storage, no reset needed
  always_ff @(posedge clk) begin
    if (nxt_wr) begin
      mem_ff[nxt_widx] <= nxt_wdat;
    end
  end

  // Bus side drive
  assign bus.card_data_out               = dout_ff;
  assign bus.card_data_oe_n              = doe_n_ff;
  assign bus.card_wait_out               = 1'b0;
  assign bus.card_wait_oe_n              = (st_ff != ocb_pkg::CS_HOLD);
  assign bus.card_nmi_out                = 1'b0;
  assign bus.card_nmi_oe_n               = nmi_oe_n_ff;
  assign bus.card_interrupt_requests     = irq_ff[ocb_pkg::IRQ_LINE4:ocb_pkg::IRQ_LINE2];
  assign bus.bus_request_interrupt_line  = irq_ff[ocb_pkg::IRQ_BUSREQ];
  assign bus.refresh_shared_request_line = irq_ff[ocb_pkg::IRQ_REFRESH];
  assign wr_valid                        = wr_ff;
  assign wr_index                        = widx_ff;
  assign wr_data                         = wdat_ff;
  assign count_done_seen                 = eoc_ff;
endmodule : ocb_card
`default_nettype wire

/* File: rtl/ocb_host.sv */
// Host end of the option card bus: bus cycles, wait, interrupts, reset
`timescale 1ns/10ps
`default_nettype none
module ocb_host #(
  parameter int DIV_SLOW = ocb_pkg::DIV_SLOW,
  parameter int DIV_FAST = ocb_pkg::DIV_FAST
) (
  input  wire logic                             clk,
  input  wire logic                             reset,
  ocb_if.host_mp                                bus,
  input  wire logic                             fast_mode,
  input  wire logic                             low_voltage,
  input  wire logic                             dma_grant,
  input  wire logic                             req_valid,
  output logic                                  req_ready,
  input  wire logic                             req_write,
  input  wire logic                             req_io,
  input  wire logic [ocb_pkg::ADDR_W-1:0]       req_addr,
  input  wire logic [ocb_pkg::DATA_W-1:0]       req_wdata,
  output logic                                  rsp_valid,
  output logic [ocb_pkg::DATA_W-1:0]            rsp_rdata,
  output logic [ocb_pkg::ADDR_W-1:0]            latched_addr,
  input  wire logic                             dma_count_done,
  output logic [ocb_pkg::IRQ_N-1:0]             irq_pending,
  output logic                                  irq_active,
  output logic [ocb_pkg::IRQ_IDX_W-1:0]         irq_index,
  input  wire logic                             irq_ack,
  input  wire logic [ocb_pkg::IRQ_IDX_W-1:0]    irq_ack_index,
  output logic                                  parity_error
);
  // Bus clock divider state
  logic [ocb_pkg::DIV_W-1:0]            div_ff, nxt_div;
  logic                                 bclk_ff, nxt_bclk;
  logic [ocb_pkg::DIV_W-1:0]            period, half;
  logic                                 rise, fall;

  // Reset output and its synchroniser
  logic                                 lv_meta_ff, lv_ff;
  logic                                 brst_ff, nxt_brst;

  // Cycle state
  ocb_pkg::ocb_host_st_e                st_ff, nxt_st;
  logic [ocb_pkg::ADDR_W-1:0]           addr_ff, nxt_addr;
  logic [ocb_pkg::ADDR_W-1:0]           lat_ff, nxt_lat;
  logic                                 ale_ff, nxt_ale;
  logic                                 own_ff, nxt_own;
  logic                                 we_ff, nxt_we;
  logic                                 io_ff, nxt_io;
  logic [ocb_pkg::CMD_W-1:0]            cmd_ff, nxt_cmd;
  logic [ocb_pkg::DATA_W-1:0]           dout_ff, nxt_dout;
  logic                                 doe_n_ff, nxt_doe_n;
  logic                                 rsp_ff, nxt_rsp;
  logic [ocb_pkg::DATA_W-1:0]           rdata_ff, nxt_rdata;
  logic                                 eoc_ff;

  // Interrupt and parity state
  logic [ocb_pkg::IRQ_N-1:0]            irq_raw;
  logic [ocb_pkg::IRQ_N-1:0]            irq_meta_ff, irq_sync_ff, irq_prev_ff;
  logic [ocb_pkg::IRQ_N-1:0]            pend_ff, nxt_pend;
  logic                                 act_ff, nxt_act;
  logic [ocb_pkg::IRQ_IDX_W-1:0]        idx_ff, nxt_idx;
  logic                                 nmi_meta_ff, nmi_ff;

  // Bus clock divider; ticks line up with the bus clock edges
  always_comb begin
    period   = fast_mode ? ocb_pkg::DIV_W'(DIV_FAST) : ocb_pkg::DIV_W'(DIV_SLOW);
    half     = period >> 1;
    nxt_div  = (div_ff >= period - 3'h1) ? 3'h0 : div_ff + 3'h1;
    nxt_bclk = (nxt_div < half);
    rise     = (nxt_div == 3'h0);
    fall     = (nxt_div == half);
    nxt_brst = fall ? lv_ff : brst_ff;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div_ff     <= '0;
      bclk_ff    <= 1'b0;
      lv_meta_ff <= 1'b0;
      lv_ff      <= 1'b0;
      brst_ff    <= ocb_pkg::BUS_RESET_OUTPUT_INIT;
    end else begin
      div_ff     <= nxt_div;
      bclk_ff    <= nxt_bclk;
      lv_meta_ff <= low_voltage;
      lv_ff      <= lv_meta_ff;
      brst_ff    <= nxt_brst;
    end
  end

  // Bus cycle sequencer, advancing on bus clock rising ticks
  always_comb begin
    nxt_st    = st_ff;
    nxt_addr  = addr_ff;
    nxt_ale   = ale_ff;
    nxt_own   = own_ff;
    nxt_we    = we_ff;
    nxt_io    = io_ff;
    nxt_cmd   = cmd_ff;
    nxt_dout  = dout_ff;
    nxt_doe_n = doe_n_ff;
    nxt_rsp   = 1'b0;
    nxt_rdata = rdata_ff;
    req_ready = (st_ff == ocb_pkg::ST_IDLE) && rise && !brst_ff;
    case (st_ff)
      ocb_pkg::ST_IDLE: begin
        if (rise) begin
          nxt_own = dma_grant;
          if (req_valid && !brst_ff) begin
            nxt_addr = req_addr;
            nxt_we   = req_write;
            nxt_io   = req_io;
            nxt_dout = req_wdata;
            nxt_ale  = !dma_grant;
            nxt_st   = ocb_pkg::ST_ADDR;
          end
        end
      end
      ocb_pkg::ST_ADDR: begin
        if (rise) begin
          nxt_ale = 1'b0;
          nxt_cmd = ocb_pkg::CMD_IDLE;
          if (io_ff) begin
            nxt_cmd[ocb_pkg::CMD_IOW] = !we_ff;
            nxt_cmd[ocb_pkg::CMD_IOR] = we_ff;
          end else begin
            nxt_cmd[ocb_pkg::CMD_MEMW] = !we_ff;
            nxt_cmd[ocb_pkg::CMD_MEMR] = we_ff;
          end
          nxt_doe_n = !we_ff;
          nxt_st    = ocb_pkg::ST_CMD;
        end
      end
      ocb_pkg::ST_CMD: begin
        if (rise) begin
          nxt_st = ocb_pkg::ST_SAMPLE;
        end
      end
      ocb_pkg::ST_SAMPLE: begin
        // Wait low holds here a whole bus clock at a time
        if (rise && bus.bus_wait_line) begin
          nxt_cmd   = ocb_pkg::CMD_IDLE;
          nxt_doe_n = 1'b1;
          nxt_rsp   = 1'b1;
          if (!we_ff) begin
            nxt_rdata = bus.data;
          end
          nxt_st    = ocb_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st    = ocb_pkg::ST_IDLE;
        nxt_cmd   = ocb_pkg::CMD_IDLE;
        nxt_doe_n = 1'b1;
        nxt_ale   = 1'b0;
      end
    endcase
    // System address latch follows the strobe's falling edge
    nxt_lat = (ale_ff && !nxt_ale) ? addr_ff : lat_ff;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff    <= ocb_pkg::ST_IDLE;
      addr_ff  <= '0;
      lat_ff   <= '0;
      ale_ff   <= 1'b0;
      own_ff   <= 1'b0;
      we_ff    <= 1'b0;
      io_ff    <= 1'b0;
      cmd_ff   <= ocb_pkg::CMD_IDLE;
      dout_ff  <= '0;
      doe_n_ff <= 1'b1;
      rsp_ff   <= 1'b0;
      rdata_ff <= '0;
      eoc_ff   <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      addr_ff  <= nxt_addr;
      lat_ff   <= nxt_lat;
      ale_ff   <= nxt_ale;
      own_ff   <= nxt_own;
      we_ff    <= nxt_we;
      io_ff    <= nxt_io;
      cmd_ff   <= nxt_cmd;
      dout_ff  <= nxt_dout;
      doe_n_ff <= nxt_doe_n;
      rsp_ff   <= nxt_rsp;
      rdata_ff <= nxt_rdata;
      eoc_ff   <= dma_count_done;
    end
  end

  // Interrupt capture on rising request, fixed priority pick
  always_comb begin
    irq_raw = {bus.refresh_shared_request_line, bus.bus_request_interrupt_line,
               bus.card_interrupt_requests};
    nxt_pend = pend_ff;
    if (irq_ack) begin
      nxt_pend[irq_ack_index] = 1'b0;
    end
    nxt_pend = nxt_pend | (irq_sync_ff & ~irq_prev_ff);
    nxt_act  = |nxt_pend;
    nxt_idx  = '0;
    for (int i = ocb_pkg::IRQ_N - 1; i >= 0; i--) begin
      if (nxt_pend[i]) begin
        nxt_idx = ocb_pkg::IRQ_IDX_W'(i);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_meta_ff <= '0;
      irq_sync_ff <= '0;
      irq_prev_ff <= '0;
      pend_ff     <= '0;
      act_ff      <= 1'b0;
      idx_ff      <= '0;
      nmi_meta_ff <= 1'b1;
      nmi_ff      <= 1'b1;
    end else begin
      irq_meta_ff <= irq_raw;
      irq_sync_ff <= irq_meta_ff;
      irq_prev_ff <= irq_sync_ff;
      pend_ff     <= nxt_pend;
      act_ff      <= nxt_act;
      idx_ff      <= nxt_idx;
      nmi_meta_ff <= bus.nmi_n;
      nmi_ff      <= nmi_meta_ff;
    end
  end

  // Bus and user side drive
  assign bus.bus_clk                  = bclk_ff;
  assign bus.bus_reset_output         = brst_ff;
  assign bus.addr                     = addr_ff;
  assign bus.ale                      = ale_ff;
  assign bus.dma_address_enable       = own_ff;
  assign bus.cmd_n                    = cmd_ff;
  assign bus.dma_terminal_count_pulse = eoc_ff;
  assign bus.host_data_out            = dout_ff;
  assign bus.host_data_oe_n           = doe_n_ff;
  assign rsp_valid                    = rsp_ff;
  assign rsp_rdata                    = rdata_ff;
  assign latched_addr                 = lat_ff;
  assign irq_pending                  = pend_ff;
  assign irq_active                   = act_ff;
  assign irq_index                    = idx_ff;
  assign parity_error                 = !nmi_ff;
endmodule : ocb_host
`default_nettype wire

/* File: rtl/ocb_if.sv */
// Option card bus wires joining the host end and one card end
`timescale 1ns/10ps
`default_nettype none
interface ocb_if;
  logic                             bus_clk;
  logic                             bus_reset_output;
  logic [ocb_pkg::ADDR_W-1:0]       addr;
  logic                             ale;
  logic                             dma_address_enable;
  logic [ocb_pkg::CMD_W-1:0]        cmd_n;
  logic                             dma_terminal_count_pulse;
  logic [ocb_pkg::DATA_W-1:0]       host_data_out;
  logic                             host_data_oe_n;
  logic [ocb_pkg::DATA_W-1:0]       card_data_out;
  logic                             card_data_oe_n;
  logic [ocb_pkg::DATA_W-1:0]       data;
  logic                             card_wait_out;
  logic                             card_wait_oe_n;
  logic                             bus_wait_line;
  logic                             card_nmi_out;
  logic                             card_nmi_oe_n;
  logic                             nmi_n;
  logic [2:0]                       card_interrupt_requests;
  logic                             bus_request_interrupt_line;
  logic                             refresh_shared_request_line;

  // Shared data bus, pulled high when nobody drives
  assign data = !host_data_oe_n ? host_data_out :
                (!card_data_oe_n ? card_data_out : ocb_pkg::BUS_FLOAT);
  // Open-drain wait and parity lines with pull-ups
  assign bus_wait_line = card_wait_oe_n ? 1'b1 : card_wait_out;
  assign nmi_n         = card_nmi_oe_n ? 1'b1 : card_nmi_out;

  modport host_mp (
    output bus_clk, bus_reset_output, addr, ale, dma_address_enable, cmd_n,
    output dma_terminal_count_pulse, host_data_out, host_data_oe_n,
    input  data, bus_wait_line, nmi_n, card_interrupt_requests,
    input  bus_request_interrupt_line, refresh_shared_request_line
  );
  modport card_mp (
    input  bus_clk, bus_reset_output, addr, ale, dma_address_enable, cmd_n,
    input  dma_terminal_count_pulse, data,
    output card_data_out, card_data_oe_n, card_wait_out, card_wait_oe_n,
    output card_nmi_out, card_nmi_oe_n, card_interrupt_requests,
    output bus_request_interrupt_line, refresh_shared_request_line
  );
endinterface : ocb_if
`default_nettype wire

/* File: rtl/ocb_pkg.sv */
// Shared constants and types for the option card bus host and card ends
package ocb_pkg;
  // Clock and bus clock timing
  localparam int CLK_NS      = 50;
  localparam int BUS_SLOW_NS = 210;
  localparam int BUS_FAST_NS = 140;
  localparam int DIV_SLOW    = BUS_SLOW_NS / CLK_NS;
  localparam int DIV_FAST    = BUS_FAST_NS / CLK_NS;
  localparam int DIV_W       = 3;
  // Widths
  localparam int ADDR_W      = 20;
  localparam int DATA_W      = 8;
  localparam int IRQ_N       = 5;
  localparam int IRQ_IDX_W   = 3;
  localparam int CMD_W       = 4;
  // Interrupt line positions, highest priority first
  localparam int IRQ_LINE2   = 0;
  localparam int IRQ_LINE3   = 1;
  localparam int IRQ_LINE4   = 2;
  localparam int IRQ_BUSREQ  = 3;
  localparam int IRQ_REFRESH = 4;
  // Command vector bit positions, all active low
  localparam int CMD_IOR     = 3;
  localparam int CMD_IOW     = 2;
  localparam int CMD_MEMR    = 1;
  localparam int CMD_MEMW    = 0;
  // Card limits and layout
  localparam int MAX_WAIT_CLKS = 10;
  localparam int WAIT_CNT_W    = 4;
  localparam int CARD_WORDS    = 16;
  localparam int CARD_IDX_W    = 4;
  // Reset values and the undriven data bus level
  localparam logic [CMD_W-1:0] CMD_IDLE    = 4'hF;
  localparam logic             BUS_RESET_OUTPUT_INIT = 1'b1;
  localparam logic [DATA_W-1:0] BUS_FLOAT  = 8'hFF;
  // Host cycle states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ADDR   = 4'h2,
    ST_CMD    = 4'h4,
    ST_SAMPLE = 4'h8
  } ocb_host_st_e;
  // Card wait states
  typedef enum logic [2:0] {
    CS_IDLE = 3'h1,
    CS_HOLD = 3'h2,
    CS_DONE = 3'h4
  } ocb_card_st_e;
endpackage : ocb_pkg
